// file: logic/dsf_pkg.sv
/*
  Shared constants and types for the drive security command block:
  command codes, sector layout, flag bit positions, reset values.
  Assumes a 16-bit data port and 8-bit task-file registers.
*/
package dsf_pkg;

  // Command codes
  localparam logic [7:0] CMD_SETPW     = 8'hf1;
  localparam logic [7:0] CMD_UNLOCK    = 8'hf2;
  localparam logic [7:0] CMD_ERASEPREP = 8'hf3;
  localparam logic [7:0] CMD_ERASEUNIT = 8'hf4;
  localparam logic [7:0] CMD_FREEZE    = 8'hf5;
  localparam logic [7:0] CMD_DISABLE   = 8'hf6;

  // Sector layout, in 16-bit words
  localparam int         SECTOR_WORDS  = 256;
  localparam int         PW_WORDS      = 16;
  localparam logic [7:0] IDX_CTRL      = 8'h00;
  localparam logic [7:0] IDX_PW_FIRST  = 8'h01;
  localparam logic [7:0] IDX_PW_LAST   = 8'h10;
  localparam logic [7:0] IDX_REV       = 8'h11;
  localparam logic [7:0] IDX_LAST      = 8'hff;

  // Revision codes
  localparam logic [15:0] REV_DEFAULT  = 16'hfffe;
  localparam logic [15:0] REV_RESERVED = 16'hffff;

  // Status and error bit positions
  localparam int ST_BSY  = 7;
  localparam int ST_RDY  = 6;
  localparam int ST_DSC  = 4;
  localparam int ST_DRQ  = 3;
  localparam int ST_ERR  = 0;
  localparam int ERR_ABT = 2;

  // Register values: reset, busy, DRQ and abort
  localparam logic [7:0] STATUS_IDLE   = 8'h50;
  localparam logic [7:0] STATUS_BUSY   = 8'hd0;
  localparam logic [7:0] STATUS_DRQ    = 8'h58;
  localparam logic [7:0] STATUS_ABORT  = 8'h51;
  localparam logic [7:0] ERROR_NONE    = 8'h00;
  localparam logic [7:0] ERROR_ABORT   = 8'h04;
  localparam logic [7:0] DEVHEAD_RESET = 8'ha0;

  typedef enum logic [3:0] {
    DSF_IDLE = 4'b0001,
    DSF_EXEC = 4'b0010,
    DSF_XFER = 4'b0100,
    DSF_DONE = 4'b1000
  } dsf_state_e;

  // Control word 0 of the sector
  typedef struct packed {
    logic [6:0] rsvdHi;
    logic       maxLevel;
    logic [6:0] rsvdLo;
    logic       master;
  } dsf_ctrl_s;

  // Security state seen by the rest of the drive
  typedef struct packed {
    logic lockEnabled;
    logic locked;
    logic frozen;
    logic maxLevel;
  } dsf_sec_s;

endpackage

// file: logic/dsf_security_cmd.sv
/*
  Security command interpreter for freeze and set-password, with the
  unlock, disable and erase paths they interact with.
  Assumes host strobes are synchronous to ref_clk, one cycle each;
  arst_n stands for a power cycle, hardRst for an interface hard reset.
*/
`timescale 1ns/10ps

module dsf_security_cmd #(
  parameter int PW_WORDS = dsf_pkg::PW_WORDS
) (
  input  wire logic              ref_clk,
  input  wire logic              arst_n,
  input  wire logic              hardRst,
  input  wire logic              cmdWrite,
  input  wire logic [7:0]        cmdCode,
  input  wire logic              devHeadWrite,
  input  wire logic [7:0]        devHeadIn,
  input  wire logic              dataWrite,
  input  wire logic [15:0]       dataIn,
  output logic [7:0]             commandStatusFlags,
  output logic [7:0]             commandErrorFlags,
  output logic [7:0]             driveHeadSelect,
  output logic [15:0]            identifyWord92,
  output dsf_pkg::dsf_sec_s      secState,
  output logic                   eraseStart
);

  ////////////////////////////////////////////////////////////////////
  // State
  dsf_pkg::dsf_state_e state;
  dsf_pkg::dsf_state_e next_state;
  logic [7:0]          opcode;
  logic [7:0]          next_opcode;
  logic [7:0]          idx;
  logic [7:0]          next_idx;
  dsf_pkg::dsf_ctrl_s  ctrl;
  dsf_pkg::dsf_ctrl_s  next_ctrl;
  logic                miss;
  logic                next_miss;
  logic                prep;
  logic                next_prep;
  logic [15:0]         newRev;
  logic [15:0]         next_newRev;
  logic [7:0]          next_status;
  logic [7:0]          next_error;
  logic [7:0]          next_devHead;
  logic [15:0]         next_rev;
  dsf_pkg::dsf_sec_s   next_sec;
  logic                next_erase;
  logic [15:0]         userPw      [PW_WORDS];
  logic [15:0]         masterPw    [PW_WORDS];
  logic [15:0]         newPw       [PW_WORDS];
  logic [15:0]         next_userPw [PW_WORDS];
  logic [15:0]         next_masterPw [PW_WORDS];
  logic [15:0]         next_newPw  [PW_WORDS];

  // Helpers for the command decisions; all combinational, all
  // defaulted at the top so no latch can form on any path
  logic       abortCmd;
  logic       xferCmd;
  logic       match;
  logic [3:0] pwIdx;
  logic [15:0] stored;

  ////////////////////////////////////////////////////////////////////
  // Next-state computation
  always_comb begin
    next_state    = state;
    next_opcode   = opcode;
    next_idx      = idx;
    next_ctrl     = ctrl;
    next_miss     = miss;
    next_prep     = prep;
    next_newRev   = newRev;
    next_status   = commandStatusFlags;
    next_error    = commandErrorFlags;
    next_devHead  = driveHeadSelect;
    next_rev      = identifyWord92;
    next_sec      = secState;
    next_erase    = 1'b0;
    next_userPw   = userPw;
    next_masterPw = masterPw;
    next_newPw    = newPw;
    abortCmd      = 1'b0;
    xferCmd       = 1'b0;
    match         = 1'b0;
    // Word under compare follows the selector latched from word 0;
    // outside words 1-16 the index wraps but is never used
    pwIdx         = 4'(idx - dsf_pkg::IDX_PW_FIRST);
    stored        = ctrl.master ? masterPw[pwIdx] : userPw[pwIdx];

    if (devHeadWrite) begin
      next_devHead = devHeadIn;
    end

    case (state)
      // Commands only taken while neither busy nor in transfer
      dsf_pkg::DSF_IDLE: begin
        if (cmdWrite) begin
          next_opcode = cmdCode;
          next_state  = dsf_pkg::DSF_EXEC;
          next_status = dsf_pkg::STATUS_BUSY;
          next_error  = dsf_pkg::ERROR_NONE;
        end
      end
      // Decide at once: finish, abort or ask for the sector
      dsf_pkg::DSF_EXEC: begin
        case (opcode)
          dsf_pkg::CMD_FREEZE: begin
            next_sec.frozen = 1'b1;
          end
          dsf_pkg::CMD_ERASEPREP: begin
            // No data; it only arms the next erase unit below
          end
          dsf_pkg::CMD_SETPW,
          dsf_pkg::CMD_UNLOCK,
          dsf_pkg::CMD_DISABLE: begin
            abortCmd = secState.frozen;
            xferCmd  = !secState.frozen;
          end
          dsf_pkg::CMD_ERASEUNIT: begin
            // Prepare must be the command just before this one
            abortCmd = secState.frozen || !prep;
            xferCmd  = !abortCmd;
          end
          default: begin
            abortCmd = 1'b1;
          end
        endcase
        // Any command other than prepare disarms the erase
        next_prep = (opcode == dsf_pkg::CMD_ERASEPREP);
        if (xferCmd) begin
          next_state  = dsf_pkg::DSF_XFER;
          next_status = dsf_pkg::STATUS_DRQ;
          next_idx    = dsf_pkg::IDX_CTRL;
          next_miss   = 1'b0;
        end else begin
          next_state  = dsf_pkg::DSF_IDLE;
          next_status = abortCmd ? dsf_pkg::STATUS_ABORT
                                 : dsf_pkg::STATUS_IDLE;
          next_error  = abortCmd ? dsf_pkg::ERROR_ABORT
                                 : dsf_pkg::ERROR_NONE;
        end
      end
      // One sector of 256 words, compared and captured on the fly
      dsf_pkg::DSF_XFER: begin
        if (dataWrite) begin
          next_idx = 8'(idx + 8'h01);
          if (idx == dsf_pkg::IDX_CTRL) begin
            // Reserved control bits are kept but never acted on
            next_ctrl = dsf_pkg::dsf_ctrl_s'(dataIn);
          end
          if (idx >= dsf_pkg::IDX_PW_FIRST &&
              idx <= dsf_pkg::IDX_PW_LAST) begin
            // Full 16-bit compare of every word, no padding
            next_newPw[pwIdx] = dataIn;
            if (dataIn != stored) begin
              next_miss = 1'b1;
            end
          end
          // Word 18 and everything past it are reserved and dropped
          if (idx == dsf_pkg::IDX_REV) begin
            next_newRev = dataIn;
          end
          if (idx == dsf_pkg::IDX_LAST) begin
            next_state  = dsf_pkg::DSF_DONE;
            next_status = dsf_pkg::STATUS_BUSY;
          end
        end
      end
      // Commit the sector's effect
      dsf_pkg::DSF_DONE: begin
        case (opcode)
          dsf_pkg::CMD_SETPW: begin
            // No old password is needed here, so the mismatch
            // flag gathered during the sector is left unused
            if (ctrl.master) begin
              next_masterPw = newPw;
              // Reserved code is never stored
              if (newRev != dsf_pkg::REV_RESERVED) begin
                next_rev = newRev;
              end
            end else begin
              next_userPw          = newPw;
              next_sec.lockEnabled = 1'b1;
              next_sec.maxLevel    = ctrl.maxLevel;
            end
          end
          dsf_pkg::CMD_UNLOCK: begin
            // Master is refused outright at maximum level
            match = !miss && !(ctrl.master && secState.maxLevel);
            if (match) begin
              next_sec.locked = 1'b0;
            end
          end
          dsf_pkg::CMD_DISABLE: begin
            // Lock feature off; the master password stays stored
            match = !miss;
            if (match) begin
              next_sec.lockEnabled = 1'b0;
              next_sec.locked      = 1'b0;
            end
          end
          default: begin
            // Erase unit: a way out when max level is lost, as is disable with the master word
            match = !miss;
            if (match) begin
              next_sec.lockEnabled = 1'b0;
              next_sec.locked      = 1'b0;
              next_erase           = 1'b1;
            end
          end
        endcase
        abortCmd    = (opcode != dsf_pkg::CMD_SETPW) && !match;
        next_state  = dsf_pkg::DSF_IDLE;
        next_status = abortCmd ? dsf_pkg::STATUS_ABORT
                               : dsf_pkg::STATUS_IDLE;
        next_error  = abortCmd ? dsf_pkg::ERROR_ABORT
                               : dsf_pkg::ERROR_NONE;
      end
      default: begin
        // Any code outside the one-hot set falls back to idle
        next_state = dsf_pkg::DSF_IDLE;
      end
    endcase

    // Hard reset ends any command and arms the lock, keeps frozen
    // Data in flight is dropped; the host must repeat the command
    if (hardRst) begin
      next_state      = dsf_pkg::DSF_IDLE;
      next_status     = dsf_pkg::STATUS_IDLE;
      next_error      = dsf_pkg::ERROR_NONE;
      next_devHead    = dsf_pkg::DEVHEAD_RESET;
      next_prep       = 1'b0;
      next_erase      = 1'b0;
      next_sec.locked = secState.lockEnabled;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Registers; power cycle is the only clear of frozen
  // Passwords are volatile here: a power cycle loses them too
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state              <= dsf_pkg::DSF_IDLE;
      opcode             <= 8'h00;
      idx                <= 8'h00;
      ctrl               <= '0;
      miss               <= 1'b0;
      prep               <= 1'b0;
      newRev             <= dsf_pkg::REV_DEFAULT;
      commandStatusFlags <= dsf_pkg::STATUS_IDLE;
      commandErrorFlags  <= dsf_pkg::ERROR_NONE;
      driveHeadSelect    <= dsf_pkg::DEVHEAD_RESET;
      identifyWord92     <= dsf_pkg::REV_DEFAULT;
      secState           <= '0;
      eraseStart         <= 1'b0;
      for (int i = 0; i < PW_WORDS; i++) begin
        userPw[i]   <= 16'h0000;
        masterPw[i] <= 16'h0000;
        newPw[i]    <= 16'h0000;
      end
    end else begin
      state              <= next_state;
      opcode             <= next_opcode;
      idx                <= next_idx;
      ctrl               <= next_ctrl;
      miss               <= next_miss;
      prep               <= next_prep;
      newRev             <= next_newRev;
      commandStatusFlags <= next_status;
      commandErrorFlags  <= next_error;
      driveHeadSelect    <= next_devHead;
      identifyWord92     <= next_rev;
      secState           <= next_sec;
      eraseStart         <= next_erase;
      userPw             <= next_userPw;
      masterPw           <= next_masterPw;
      newPw              <= next_newPw;
    end
  end

endmodule

// file: tb/dsf_security_checker.sv
/*
  Port-level checker for the drive security command block.
  Assumes one clock domain; bound onto every dsf_security_cmd.
*/
`timescale 1ns/10ps

module dsf_security_checker #(
  parameter int PW_WORDS = 16
) (
  input wire logic              ref_clk,
  input wire logic              arst_n,
  input wire logic              hardRst,
  input wire logic              cmdWrite,
  input wire logic [7:0]        cmdCode,
  input wire logic [7:0]        commandStatusFlags,
  input wire logic [7:0]        commandErrorFlags,
  input wire logic [15:0]       identifyWord92,
  input wire dsf_pkg::dsf_sec_s secState,
  input wire logic              eraseStart
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  // Command taken: BSY and DRQ low, no hard reset in that cycle
  wire logic [7:0] st = commandStatusFlags;
  wire logic take = !st[7] && !st[3] && cmdWrite && !hardRst;
  wire logic lockCmd = cmdCode inside {8'hf1, 8'hf2, 8'hf4, 8'hf6};

  ////////////////////////////////////////////////////////////////////////////
  a_freeze_enters: assert property (
    take && cmdCode == 8'hf5 |=> st == 8'hd0 ##1
    (st == 8'h50 && secState.frozen)) else $error("freeze not entered");
  a_frozen_sticks: assert property (
    secState.frozen |=> secState.frozen) else $error("frozen lost");
  a_frozen_rejects: assert property (
    take && secState.frozen && lockCmd |=> st == 8'hd0 ##1
    (st == 8'h51 && commandErrorFlags == 8'h04)) else $error("no reject");
  a_setpw_sector: assert property (
    take && !secState.frozen && cmdCode == 8'hf1 |=> ##1 st == 8'h58)
    else $error("set password asked no data");
  a_abort_flags: assert property (
    st[0] |-> commandErrorFlags == 8'h04 && !st[7])
    else $error("error without abort");
  a_rev_valid: assert property (
    identifyWord92 != 16'hffff) else $error("reserved revision shown");
  a_rev_update: assert property (
    $changed(identifyWord92) |-> $past(st) == 8'hd0)
    else $error("revision changed outside set password");
  a_lock_reset: assert property (
    $rose(secState.locked) |-> $past(hardRst) && secState.lockEnabled)
    else $error("locked without hard reset");
  a_erase_pulse: assert property (
    eraseStart |-> st == 8'h50 ##1 !eraseStart) else $error("erase pulse");
endmodule

bind dsf_security_cmd dsf_security_checker #(.PW_WORDS(PW_WORDS)) chk_i (
  .ref_clk(ref_clk), .arst_n(arst_n), .hardRst(hardRst),
  .cmdWrite(cmdWrite), .cmdCode(cmdCode),
  .commandStatusFlags(commandStatusFlags),
  .commandErrorFlags(commandErrorFlags),
  .identifyWord92(identifyWord92), .secState(secState),
  .eraseStart(eraseStart));

// file: tb/dsf_host_model.sv
/*
  Behavioural host controller: command, sector and hard reset.
  Assumes the bench calls cmd and hard only while the drive is idle, and sector only while it waits in DRQ.
*/
`timescale 1ns/10ps

module dsf_host_model (
  input  wire logic  ref_clk,
  output logic       hardRst,
  output logic       cmdWrite,
  output logic [7:0] cmdCode,
  output logic       dataWrite,
  output logic [15:0] dataIn
);
  // Quiet bus from time zero
  initial begin
    hardRst = 1'b0;
    cmdWrite = 1'b0;
    cmdCode = 8'h00;
    dataWrite = 1'b0;
    dataIn = 16'h0000;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One-cycle strobe, then the two fixed edges to done or DRQ
  task automatic cmd(input logic [7:0] c);
    @(negedge ref_clk);
    cmdCode = c;
    cmdWrite = 1'b1;
    @(negedge ref_clk);
    cmdWrite = 1'b0;
    cmdCode = ~c; // Released lines never keep a stale code
    repeat (2) @(negedge ref_clk);
  endtask

  // Whole sector; slow spaces words so DRQ is seen across gaps
  task automatic sector(input logic [15:0] ctrl, fill, rev,
                        input logic slow);
    for (int i = 0; i < 256; i++) begin
      @(negedge ref_clk);
      dataWrite = 1'b1;
      dataIn = i == 0 ? ctrl : i <= 16 ? fill : i == 17 ? rev : 16'(i);
      if (slow || i == 255) begin
        @(negedge ref_clk);
        dataWrite = 1'b0;
        dataIn = ~dataIn;
      end
    end
    @(negedge ref_clk);
  endtask

  // Interface hard reset pulse
  task automatic hard();
    @(negedge ref_clk);
    hardRst = 1'b1;
    @(negedge ref_clk);
    hardRst = 1'b0;
  endtask
endmodule

// file: tb/dsf_tb.sv
/*
  Directed bench for the security command block.
  Assumes dsf_host_model drives the host side; checker bound.
*/
`timescale 1ns/10ps

module tb;
  logic              ref_clk = 1'b0;
  logic              arst_n = 1'b0;
  logic              devHeadWrite = 1'b0;
  logic [7:0]        devHeadIn = 8'h00;
  logic              hardRst, cmdWrite, dataWrite, ers;
  logic [7:0]        cmdCode, st, er, dh;
  logic [15:0]       dataIn, w92;
  dsf_pkg::dsf_sec_s sec;
  logic [7:0]        lockCodes [4] = '{8'hf1, 8'hf2, 8'hf6, 8'hf4};
  int                miscompares = 0;
  int                checked = 0;

  always #5 ref_clk = ~ref_clk;

  dsf_host_model host (.ref_clk(ref_clk), .hardRst(hardRst),
    .cmdWrite(cmdWrite), .cmdCode(cmdCode), .dataWrite(dataWrite),
    .dataIn(dataIn));
  dsf_security_cmd dut (.ref_clk(ref_clk), .arst_n(arst_n),
    .hardRst(hardRst), .cmdWrite(cmdWrite), .cmdCode(cmdCode),
    .devHeadWrite(devHeadWrite), .devHeadIn(devHeadIn),
    .dataWrite(dataWrite), .dataIn(dataIn), .commandStatusFlags(st),
    .commandErrorFlags(er), .driveHeadSelect(dh), .identifyWord92(w92),
    .secState(sec), .eraseStart(ers));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Data command: strobe, then the sector
  task automatic xfer(input logic [7:0] c, input logic [15:0] ctrl, fill,
                      rev, input logic slow);
    host.cmd(c);
    host.sector(ctrl, fill, rev, slow);
  endtask

  task automatic wrap_up();
    if (miscompares == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Whole run is a few thousand cycles
  initial begin
    #200000;
    miscompares++;
    wrap_up();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence: idle values, passwords, erase, then freeze
  initial begin
    repeat (12) @(negedge ref_clk);
    arst_n = 1'b1;
    chk({st, er}, 16'h5000);
    chk(w92, 16'hfffe);
    chk({8'h00, dh}, 16'h00a0);
    devHeadWrite = 1'b1;
    devHeadIn = 8'hb0;
    @(negedge ref_clk);
    devHeadWrite = 1'b0;
    chk({8'h00, dh}, 16'h00b0);
    xfer(8'hf1, 16'h0101, 16'h1111, 16'h1234, 1'b1);
    chk(w92, 16'h1234);
    host.hard();
    chk({12'h000, sec}, 16'h0000);
    xfer(8'hf1, 16'h0000, 16'h2222, 16'h5555, 1'b0);
    chk(w92, 16'h1234);
    chk({12'h000, sec}, 16'h0008);
    host.hard();
    chk({12'h000, sec}, 16'h000c);
    xfer(8'hf2, 16'h0001, 16'h1111, 16'h0000, 1'b1);
    chk({12'h000, sec}, 16'h0008);
    xfer(8'hf1, 16'h0100, 16'h3333, 16'h0000, 1'b0);
    chk({12'h000, sec}, 16'h0009);
    host.hard();
    xfer(8'hf2, 16'h0001, 16'h1111, 16'h0000, 1'b0);
    chk({st, er}, 16'h5104);
    host.cmd(8'hf4);
    chk({st, er}, 16'h5104);
    host.cmd(8'hf3);
    xfer(8'hf4, 16'h0000, 16'h2222, 16'h0000, 1'b0);
    chk({st, er}, 16'h5104);
    host.cmd(8'hf3);
    xfer(8'hf4, 16'h0000, 16'h3333, 16'h0000, 1'b1);
    chk({15'h0000, ers}, 16'h0001);
    chk({14'h0000, sec[3:2]}, 16'h0000);
    // Disable with the right user word, then an unknown code
    xfer(8'hf6, 16'h0000, 16'h3333, 16'h0000, 1'b0);
    chk({st, er}, 16'h5000);
    host.cmd(8'h00);
    chk({st, er}, 16'h5104);
    host.cmd(8'hf5);
    chk({st, er}, 16'h5000);
    chk({15'h0000, sec.frozen}, 16'h0001);
    foreach (lockCodes[i]) begin
      host.cmd(lockCodes[i]);
      chk({st, er}, 16'h5104);
    end
    host.hard();
    chk({15'h0000, sec.frozen}, 16'h0001);
    arst_n = 1'b0;
    repeat (2) @(negedge ref_clk);
    arst_n = 1'b1;
    chk({12'h000, sec}, 16'h0000);
    chk(w92, 16'hfffe);
    // Power cycle lifts the freeze: set password is taken again
    xfer(8'hf1, 16'h0000, 16'h4444, 16'h0000, 1'b0);
    chk({12'h000, sec}, 16'h0008);
    wrap_up();
  end
endmodule
